// *** inc/timer_pkg.sv ***
// How it works
// - count drops one per 100 us tick
// - enabling copies preload into count, then counts
// - preload becomes ffff on reset or disable
// - count starts at ffff after reset
// - preload writable whether running or not
// - preload write while running restarts countdown
// - at zero wrap to ffff, flag, continue
// - flag and irq only when allowed
// - flag sticky, cleared by writing one
package timer_pkg;

    // register byte offsets on the plain port
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PRELOAD = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;

    // field positions
    localparam int RUN_EN_BIT = 0;
    localparam int EXPIRED_BIT = 0;

    // values after reset, at wrap and at zero
    localparam logic [15:0] COUNT_RESET = 16'hffff;
    localparam logic [15:0] PRELOAD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_WRAP = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // timing: clock period and tick time, both in ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 100000;
    // exact division, so no rounding question arises
    localparam int TICK_CYCLES = (TICK_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

    // one bus request as the master presents it
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// *** rtl/periodic_host_timer.sv ***
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
module periodic_host_timer
    import timer_pkg::*;
(
    input wire logic i_ref_clk, // 10 MHz clock
    input wire logic i_sys_rst, // sync reset, high
    input wire bus_req_t i_bus, // register request
    output logic [31:0] o_rdata, // read data, cycle after read
    output logic o_irq // level interrupt, high
);

    // state
    // registers first, then the wires between them

    logic tick; // 100 us pulse
    logic run_en_q; // timer_config_reg run bit
    logic [15:0] timer_preload_value_q; // preload field
    logic [15:0] timer_count_value_q; // live count
    logic timer_expired_flag_q; // sticky expiry status
    logic timer_irq_allow_q; // mask bit, same layout
    logic [31:0] rdata_q; // read data register

    // decoded strobes
    logic wr_config; // write to config
    logic wr_preload; // write to preload
    logic wr_status; // write to status
    logic wr_mask; // write to mask
    logic run_en_d; // next run bit
    logic enable_rise; // run bit going 0 -> 1
    logic enable_fall; // run bit going 1 -> 0
    logic at_zero; // count sits at zero
    logic expire_evt; // wrap happened this tick
    logic flag_clear; // software write-one-to-clear

    // tick source
    // one pulse per 100 us from the free divider

    // prescaler runs on regardless of the enable, so the first
    // decrement after enabling lands anywhere within one tick
    tick_prescaler u_prescaler (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .o_tick (tick)
    );

    // address decode
    // one write strobe per writable register, no wait states

    // map, every field in the low bits:
    // config, bit 0 runs the countdown
    // preload, 16 bits, writable at any time
    // count, 16 bits, read only
    // status, bit 0 expiry, write one clears
    // mask, bit 0 lets expiry through
    // writes to other offsets are dropped silently

    // bus is on this clock already, no synchroniser needed
    assign wr_config = i_bus.wr && (i_bus.addr == OFS_CONFIG);
    assign wr_preload = i_bus.wr && (i_bus.addr == OFS_PRELOAD);
    assign wr_status = i_bus.wr && (i_bus.addr == OFS_STATUS);
    assign wr_mask = i_bus.wr && (i_bus.addr == OFS_MASK);

    // enable edges seen from the write itself
    assign run_en_d = wr_config ? i_bus.wdata[RUN_EN_BIT] : run_en_q;
    assign enable_rise = run_en_d && !run_en_q;
    assign enable_fall = !run_en_d && run_en_q;

    // countdown helpers
    assign at_zero = (timer_count_value_q == COUNT_ZERO);
    assign expire_evt = run_en_q && !wr_preload && tick && at_zero;
    assign flag_clear = wr_status && i_bus.wdata[EXPIRED_BIT];

    // config register
    // only the run bit lives here

    // run bit, plain read/write
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            run_en_q <= 1'b0;
        end else begin
            run_en_q <= run_en_d;
        end
    end

    // preload register
    // start value loaded on enabling; a wrap restarts from ffff

    // software may write at any time; dropping the enable
    // throws the value away and restores the default
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            timer_preload_value_q <= PRELOAD_RESET;
        end else if (wr_preload) begin
            timer_preload_value_q <= i_bus.wdata[15:0];
        end else if (enable_fall) begin
            timer_preload_value_q <= PRELOAD_RESET;
        end
    end

    // countdown
    // the live count, one unit per tick

    // priority: reset, enable load, new preload, tick
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            timer_count_value_q <= COUNT_RESET;
        end else if (enable_rise) begin
            // load from the stored preload on enabling
            timer_count_value_q <= timer_preload_value_q;
        end else if (run_en_q && wr_preload) begin
            // a fresh value abandons the current run
            timer_count_value_q <= i_bus.wdata[15:0];
        end else if (run_en_q && tick) begin
            if (at_zero) begin
                // wrap and keep going
                timer_count_value_q <= COUNT_WRAP;
            end else begin
                // one unit per tick
                timer_count_value_q <= timer_count_value_q - 16'h0001;
            end
        end
        // otherwise hold while disabled
    end

    // interrupt status and mask
    // one sticky bit and one mask bit, same position

    // mask bit, plain read/write
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            timer_irq_allow_q <= 1'b0;
        end else if (wr_mask) begin
            timer_irq_allow_q <= i_bus.wdata[EXPIRED_BIT];
        end
    end

    // sticky flag; an allowed wrap in the clearing cycle wins so the
    // event is not lost
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            timer_expired_flag_q <= 1'b0;
        end else if (expire_evt && timer_irq_allow_q) begin
            timer_expired_flag_q <= 1'b1;
        end else if (flag_clear) begin
            timer_expired_flag_q <= 1'b0;
        end
    end

    // level output, straight from two flops
    assign o_irq = timer_expired_flag_q && timer_irq_allow_q;

    // read port
    // registered, so a read adds no path from the decode

    // data valid only in the cycle after the read strobe;
    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_CONFIG: begin
                    rdata_q <= {31'h0000_0000, run_en_q};
                end
                OFS_PRELOAD: begin
                    rdata_q <= {16'h0000, timer_preload_value_q};
                end
                OFS_COUNT: begin
                    rdata_q <= {16'h0000, timer_count_value_q};
                end
                OFS_STATUS: begin
                    rdata_q <= {31'h0000_0000, timer_expired_flag_q};
                end
                OFS_MASK: begin
                    rdata_q <= {31'h0000_0000, timer_irq_allow_q};
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_q;

    // checks
    // sequences first, then one property per behaviour

    // software turns the timer on
    sequence seq_enable_write;
        wr_config && i_bus.wdata[RUN_EN_BIT] && !run_en_q;
    endsequence

    // running tick at zero with no competing preload write
    sequence seq_tick_at_zero;
        run_en_q && tick && at_zero && !wr_preload;
    endsequence

    // running tick above zero, nothing else going on
    sequence seq_plain_tick;
        run_en_q && tick && !at_zero && !wr_preload && !wr_config;
    endsequence

    // register read taken this cycle
    sequence seq_read_cycle;
        i_bus.rd;
    endsequence

    // running timer switched off by software
    sequence seq_disable_write;
        wr_config && !i_bus.wdata[RUN_EN_BIT] && run_en_q;
    endsequence

    // status write that leaves the flag bit at zero
    sequence seq_zero_write;
        wr_status && !i_bus.wdata[EXPIRED_BIT];
    endsequence

    // preload written while the timer is idle
    sequence seq_idle_preload;
        wr_preload && !run_en_q;
    endsequence

    a_tick_decrement: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_plain_tick |=> timer_count_value_q == $past(timer_count_value_q) - 16'h0001)
        else $error("count did not drop by one on tick");

    a_enable_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_enable_write |=> timer_count_value_q == $past(timer_preload_value_q) && run_en_q)
        else $error("enable did not load preload");

    a_disable_default: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $fell(run_en_q) && !$past(wr_preload) |-> timer_preload_value_q == PRELOAD_RESET)
        else $error("preload not restored on disable");

    a_reset_values: assert property (@(posedge i_ref_clk)
        $past(i_sys_rst) && !i_sys_rst |-> timer_count_value_q == COUNT_RESET
            && timer_preload_value_q == PRELOAD_RESET && !o_irq)
        else $error("wrong values after reset");

    a_preload_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_preload |=> timer_preload_value_q == $past(i_bus.wdata[15:0]))
        else $error("preload write not stored");

    a_restart_run: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        run_en_q && wr_preload && !wr_config |=> timer_count_value_q == $past(i_bus.wdata[15:0]))
        else $error("preload write did not restart count");

    a_wrap_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_tick_at_zero ##0 timer_irq_allow_q |=> timer_count_value_q == COUNT_WRAP
            && timer_expired_flag_q ##1 timer_count_value_q == COUNT_WRAP)
        else $error("wrap at zero wrong");

    a_flag_allowed: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(timer_expired_flag_q) |-> $past(timer_irq_allow_q) && $past(expire_evt))
        else $error("flag set without allow");

    a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        timer_expired_flag_q && !flag_clear |=> timer_expired_flag_q)
        else $error("flag dropped without clear");

    a_clear_one: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        flag_clear && !expire_evt |=> !timer_expired_flag_q ##0 !o_irq)
        else $error("write one did not clear flag");

    a_idle_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !run_en_q && !wr_config |=> $stable(timer_count_value_q))
        else $error("count moved while disabled");

    // count read back as it stood at the strobe
    a_read_count: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_read_cycle ##0 (i_bus.addr == OFS_COUNT) |=> o_rdata == {16'h0000, $past(timer_count_value_q)})
        else $error("count read back wrong");

    // preload read back in the low half
    a_read_preload: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_read_cycle ##0 (i_bus.addr == OFS_PRELOAD) |=> o_rdata == {16'h0000, $past(timer_preload_value_q)})
        else $error("preload read back wrong");

    // status read shows the sticky flag
    a_read_status: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_read_cycle ##0 (i_bus.addr == OFS_STATUS) |=> o_rdata == {31'h0000_0000, $past(timer_expired_flag_q)})
        else $error("status read back wrong");

    // mask read shows the allow bit
    a_read_mask: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_read_cycle ##0 (i_bus.addr == OFS_MASK) |=> o_rdata == {31'h0000_0000, $past(timer_irq_allow_q)})
        else $error("mask read back wrong");

    // config read shows the run bit
    a_read_config: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_read_cycle ##0 (i_bus.addr == OFS_CONFIG) |=> o_rdata == {31'h0000_0000, $past(run_en_q)})
        else $error("config read back wrong");

    // run bit takes the written value
    a_run_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_config |=> run_en_q == $past(i_bus.wdata[RUN_EN_BIT]))
        else $error("run bit not stored");

    // mask bit takes the written value
    a_mask_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_mask |=> timer_irq_allow_q == $past(i_bus.wdata[EXPIRED_BIT]))
        else $error("mask bit not stored");

    // masked wrap leaves the flag and the line low
    a_masked_wrap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_tick_at_zero ##0 (!timer_irq_allow_q && !timer_expired_flag_q) |=> !timer_expired_flag_q && !o_irq)
        else $error("flag set while masked");

    // writing zero to status keeps the flag
    a_zero_write_keeps: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_zero_write ##0 timer_expired_flag_q |=> timer_expired_flag_q)
        else $error("zero write cleared flag");

    // between ticks a running count stays put
    a_tick_only: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        run_en_q && !tick && !wr_preload && !wr_config |=> $stable(timer_count_value_q))
        else $error("count moved without tick");

    // switching off freezes the count where it is
    a_disable_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_disable_write ##0 !tick |=> $stable(timer_count_value_q) && !run_en_q)
        else $error("count moved on disable");

    // a running tick at zero, with no preload write, turns the count into the wrap value
    a_count_wrap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_tick_at_zero |=> timer_count_value_q == COUNT_WRAP)
        else $error("count did not wrap");

    // run bit only rises on a write of one
    a_rose_needs_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(run_en_q) |-> $past(wr_config) && $past(i_bus.wdata[RUN_EN_BIT]))
        else $error("run bit rose by itself");

    // run bit only falls on a write of zero
    a_fell_needs_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $fell(run_en_q) |-> $past(wr_config) && !$past(i_bus.wdata[RUN_EN_BIT]))
        else $error("run bit fell by itself");

    // idle preload write is stored and leaves the count alone
    a_idle_preload: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        seq_idle_preload |=> $stable(timer_count_value_q) && timer_preload_value_q == $past(i_bus.wdata[15:0]))
        else $error("idle preload write wrong");

    // control bits and read data idle after reset
    a_reset_idle: assert property (@(posedge i_ref_clk)
        $past(i_sys_rst) && !i_sys_rst |-> !run_en_q && !timer_expired_flag_q && !timer_irq_allow_q
            && o_rdata == 32'h0000_0000)
        else $error("control bits not idle after reset");

endmodule // periodic_host_timer

// *** rtl/tick_prescaler.sv ***
`timescale 1ns/1ns
module tick_prescaler
    import timer_pkg::*;
(
    input wire logic i_ref_clk, // 10 MHz clock
    input wire logic i_sys_rst, // sync reset, high
    output logic o_tick // one-cycle tick each 100 us
);

    logic [9:0] div_q; // cycle counter
    logic tick_q; // registered tick

    // free running divider, never gated by the timer enable
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_q <= 10'h000;
            tick_q <= 1'b0;
        end else if (div_q == TICK_LAST) begin
            div_q <= 10'h000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 10'h001;
            tick_q <= 1'b0;
        end
    end

    assign o_tick = tick_q;

    // ticks are never closer than a handful of cycles
    a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        tick_q |=> (!tick_q) [*8])
        else $error("tick repeated too soon");

endmodule // tick_prescaler

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb
    import timer_pkg::*;
;
    logic i_ref_clk = 1'b0; // 10 mhz bench clock
    logic i_sys_rst = 1'b1; // sync reset, held at start
    bus_req_t bus = '0; // register request to the block
    logic [31:0] o_rdata; // read data from the block
    logic o_irq; // level interrupt
    int mismatches = 0; // failed comparisons
    int n_tests = 0; // comparisons made
    int cyc = 0; // free cycle count for tick spacing
    int t_last = 0; // cycle at which the last tick was seen
    logic [31:0] v0; // scratch read values
    logic [31:0] v1;

    // half period of 50 ns gives 100 ns
    always #50 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;

    periodic_host_timer dut (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_bus(bus),
        .o_rdata(o_rdata),
        .o_irq(o_irq)
    );

    // compare a bus word
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    // compare the interrupt line, sampled mid-cycle
    task automatic chk1(input logic exp, input string what);
        n_tests++;
        if (o_irq !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: irq %b, expected %b", $time, what, o_irq, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        bus <= '0;
    endtask

    // one-cycle read strobe; data only stands in the following cycle
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        bus <= '0;
        @(negedge i_ref_clk);
        d = o_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        bus_rd(a, d);
        chk32(d, exp, what);
    endtask

    // poll the count until it moves; polling is a steady 2 cycles
    task automatic wait_tick(output logic [31:0] now);
        logic [31:0] first;
        bus_rd(OFS_COUNT, first);
        now = first;
        for (int i = 0; i < 800 && now === first; i++) bus_rd(OFS_COUNT, now);
        t_last = cyc;
    endtask

    task automatic t_reset;
        rd_chk(OFS_CONFIG, 32'h0000_0000, "config after reset");
        rd_chk(OFS_MASK, 32'h0000_0000, "mask after reset");
        rd_chk(OFS_PRELOAD, 32'h0000_ffff, "preload after reset");
        rd_chk(OFS_COUNT, 32'h0000_ffff, "count after reset");
        rd_chk(OFS_STATUS, 32'h0000_0000, "status after reset");
        rd_chk(8'h14, 32'h0000_0000, "unmapped read");
        chk1(1'b0, "irq after reset");
        $display("test reset done");
    endtask

    // preload takes while idle and the count stays put past a tick
    task automatic t_idle;
        bus_wr(OFS_PRELOAD, 32'h0000_1234);
        rd_chk(OFS_PRELOAD, 32'h0000_1234, "idle preload");
        repeat (1100) @(posedge i_ref_clk);
        rd_chk(OFS_COUNT, 32'h0000_ffff, "idle count holds");
        $display("test idle done");
    endtask

    // spacing of ticks and one count per tick
    task automatic t_run;
        int t1;
        bus_wr(OFS_MASK, 32'h0000_0001);
        bus_wr(OFS_CONFIG, 32'h0000_0001);
        wait_tick(v0);
        t1 = t_last;
        wait_tick(v1);
        chk32(v1, v0 - 32'd1, "one count per tick");
        chk32(32'(t_last - t1), 32'(TICK_CYCLES), "tick spacing");
        $display("test run done");
    endtask

    // disable, reload and restart, done right after a tick
    task automatic t_reload;
        wait_tick(v0);
        bus_wr(OFS_CONFIG, 32'h0000_0000);
        rd_chk(OFS_PRELOAD, 32'h0000_ffff, "preload on disable");
        rd_chk(OFS_COUNT, v0, "count holds on disable");
        bus_wr(OFS_PRELOAD, 32'h0000_0003);
        bus_wr(OFS_CONFIG, 32'h0000_0001);
        rd_chk(OFS_COUNT, 32'h0000_0003, "enable loads count");
        wait_tick(v1);
        chk32(v1, 32'h0000_0002, "count after load");
        bus_wr(OFS_PRELOAD, 32'h0000_0007);
        rd_chk(OFS_COUNT, 32'h0000_0007, "restart on preload");
        $display("test reload done");
    endtask

    // wrap with and without the interrupt allowed
    task automatic t_wrap(input logic allow);
        bus_wr(OFS_MASK, {31'h0, allow});
        wait_tick(v0);
        bus_wr(OFS_PRELOAD, 32'h0000_0001);
        wait_tick(v1);
        chk32(v1, 32'h0000_0000, "reach zero");
        chk1(1'b0, "no irq before wrap");
        wait_tick(v1);
        chk32(v1, 32'h0000_ffff, "wrap value");
        rd_chk(OFS_STATUS, {31'h0, allow}, "flag at wrap");
        chk1(allow, "irq at wrap");
        wait_tick(v1);
        chk32(v1, 32'h0000_fffe, "keeps counting");
        $display("test wrap done");
    endtask

    // sticky flag, mask gating and write-one clear
    task automatic t_clear;
        bus_wr(OFS_STATUS, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_0001, "zero write keeps flag");
        bus_wr(OFS_MASK, 32'h0000_0000);
        @(negedge i_ref_clk);
        chk1(1'b0, "masked irq low");
        bus_wr(OFS_MASK, 32'h0000_0001);
        @(negedge i_ref_clk);
        chk1(1'b1, "unmasked irq high");
        bus_wr(OFS_STATUS, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'h0000_0000, "one write clears");
        chk1(1'b0, "irq after clear");
        $display("test clear done");
    endtask

    task results;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // run needs about 13k cycles; cut a hang well beyond that
    initial begin
        repeat (40000) @(posedge i_ref_clk);
        mismatches++;
        results();
    end

    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_idle();
        t_run();
        t_reload();
        t_wrap(1'b0);
        t_wrap(1'b1);
        t_clear();
        results();
    end
endmodule // tb
